// ### pkg/wgsoc_pkg.sv
`default_nettype none

package wgsoc_pkg;

    // ****************************************************************
    // Clock rates
    // ****************************************************************
    localparam int unsigned CLOCK_FREQ_KHZ    = 25000;
    localparam int unsigned FAST_OSC_FREQ_KHZ = 16000;
    localparam int unsigned OSC_ACC_WIDTH     = 6;
    localparam logic [5:0]  OSC_STEP          = 6'(FAST_OSC_FREQ_KHZ / 1000);
    localparam logic [5:0]  OSC_MODULUS       = 6'(CLOCK_FREQ_KHZ / 1000);
    localparam logic [5:0]  OSC_ACC_RESET     = 6'h00;

    // ****************************************************************
    // Clock source select encoding
    // ****************************************************************
    localparam logic CLK_SEL_SYSTEM = 1'b0;
    localparam logic CLK_SEL_FAST   = 1'b1;

    // ****************************************************************
    // Input source select encoding
    // ****************************************************************
    typedef enum logic [3:0] {
        SRC_PIN_REMAP   = 4'h0,
        SRC_COMP_ONE    = 4'h1,
        SRC_COMP_TWO    = 4'h2,
        SRC_CAPCMP_ONE  = 4'h3,
        SRC_CAPCMP_TWO  = 4'h4,
        SRC_LOGIC_ONE   = 4'h5,
        SRC_LOGIC_TWO   = 4'h6,
        SRC_LOGIC_THREE = 4'h7,
        SRC_LOGIC_FOUR  = 4'h8,
        SRC_PWM_THREE   = 4'h9,
        SRC_PWM_FOUR    = 4'hA
    } wgsoc_source_t;

    // ****************************************************************
    // Output stage
    // ****************************************************************
    localparam int unsigned NUM_OUTPUTS       = 4;
    localparam logic [3:0]  COMPLEMENT_MASK   = 4'hA;
    localparam logic [3:0]  PIN_OUT_RESET     = 4'h0;
    localparam logic [3:0]  PIN_EN_N_RESET    = 4'hF;
    localparam logic        WAVE_RESET        = 1'b0;
    localparam logic [1:0]  REMAP_SYNC_RESET  = 2'h0;

endpackage

`default_nettype wire

// ### src/wgsoc_clock_select.sv
`timescale 1ns/1ps
`default_nettype none

module wgsoc_clock_select
    import wgsoc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic clock_enable,
    // Control
    input  wire logic clock_source_select,
    // Tick
    output logic      tick
);

    logic [5:0] acc_q;
    logic [5:0] acc_d;
    logic [5:0] sum;
    logic       wrap;

    // ****************************************************************
    // Fast oscillator model
    // ****************************************************************
    // The fast oscillator is modelled as a fractional enable of the
    // system clock: on average 16 ticks in every 25 cycles. This keeps
    // one clock domain at the cost of a small tick-to-tick jitter.
    always_comb begin
        sum   = acc_q + OSC_STEP;
        wrap  = (sum >= OSC_MODULUS);
        acc_d = acc_q;
        if (clock_enable) begin
            acc_d = wrap ? 6'(sum - OSC_MODULUS) : sum;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            acc_q <= OSC_ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // RULE_01: pick clock source.
    assign tick = (clock_source_select == CLK_SEL_SYSTEM) ? clock_enable : (clock_enable & wrap);

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_SYS_TICK_EVERY_CYCLE: assert property ( // RULE_01
        (clock_source_select == CLK_SEL_SYSTEM) && clock_enable |-> tick)
        else $error("System clock source missed a tick.");

    AST_FAST_NO_TWO_GAPS: assert property ( // RULE_01
        (clock_source_select == CLK_SEL_FAST) && clock_enable && !tick ##1
        (clock_source_select == CLK_SEL_FAST) && clock_enable |-> tick)
        else $error("Fast oscillator rate fell below sixteen of twenty-five.");

    AST_FAST_HAS_GAPS: assert property ( // RULE_01
        ((clock_source_select == CLK_SEL_FAST) && clock_enable)[*3] |-> !$past(tick, 2) || !$past(tick) || !tick)
        else $error("Fast oscillator ran at the system clock rate.");

endmodule

`default_nettype wire

// ### src/wgsoc_source_output.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: Clock from system or 16 MHz oscillator.
// RULE_02: One of eleven sources feeds the waveform.
// RULE_03: Four outputs, each with own enable.
// RULE_04: Cleared enable releases the pin entirely.
// RULE_05: Set enable drives override or waveform.
// RULE_06: Module disabled means no pin control.
// RULE_07: Polarity bit set means active high.
// RULE_08: Override levels never inverted by polarity.
// RULE_09: Steering and shutdown ignore polarity settings.
// RULE_10: Selected input sampled on selected clock.
module wgsoc_source_output
    import wgsoc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       clock_enable,
    // Configuration
    input  wire logic       module_enable,
    input  wire logic       clock_source_select,
    input  wire logic [3:0] input_select,
    input  wire logic [3:0] output_enable_bits,
    input  wire logic [3:0] output_polarity_bits,
    input  wire logic [3:0] override_select,
    input  wire logic [3:0] override_levels,
    // Waveform sources
    input  wire logic       peripheral_pin_remap,
    input  wire logic       comparator_one_synced,
    input  wire logic       comparator_two_synced,
    input  wire logic       capture_compare_one_output,
    input  wire logic       capture_compare_two_output,
    input  wire logic       logic_cell_one_output,
    input  wire logic       logic_cell_two_output,
    input  wire logic       logic_cell_three_output,
    input  wire logic       logic_cell_four_output,
    input  wire logic       pulse_width_three_output,
    input  wire logic       pulse_width_four_output,
    // Output pins
    output logic [3:0]      pin_out,
    output logic [3:0]      pin_out_en_n,
    // Status
    output logic            source_level,
    output logic            source_select_valid
);

    logic [1:0] remap_sync_q;
    logic [1:0] remap_sync_d;
    logic       tick;
    logic       step;
    logic       selected;
    logic       sel_valid;
    logic       wave_q;
    logic       wave_d;
    logic [3:0] raw_wave;
    logic [3:0] pin_out_q;
    logic [3:0] pin_out_d;
    logic [3:0] pin_en_n_q;
    logic [3:0] pin_en_n_d;
    logic [3:0] driving;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic apply_polarity(input logic level, input logic active_high);
        apply_polarity = active_high ? level : ~level;
    endfunction

    // ****************************************************************
    // Clock source
    // ****************************************************************
    wgsoc_clock_select u_clock_select (
        .clock               (clock),
        .reset               (reset),
        .clock_enable        (clock_enable),
        .clock_source_select (clock_source_select),
        .tick                (tick)
    );

    assign step = clock_enable & tick;

    // ****************************************************************
    // Input source selection
    // ****************************************************************
    // The remapped pin comes straight from a pad, so it is synchronised
    // before anything looks at it. The other sources are on-chip logic
    // on this clock and need no synchroniser.
    always_comb begin
        remap_sync_d = remap_sync_q;
        if (clock_enable) begin
            remap_sync_d = {remap_sync_q[0], peripheral_pin_remap};
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            remap_sync_q <= REMAP_SYNC_RESET;
        end else begin
            remap_sync_q <= remap_sync_d;
        end
    end

    // RULE_02: eleven-way source mux.
    always_comb begin
        sel_valid = 1'b1;
        unique case (wgsoc_source_t'(input_select))
            SRC_PIN_REMAP:   selected = remap_sync_q[1];
            SRC_COMP_ONE:    selected = comparator_one_synced;
            SRC_COMP_TWO:    selected = comparator_two_synced;
            SRC_CAPCMP_ONE:  selected = capture_compare_one_output;
            SRC_CAPCMP_TWO:  selected = capture_compare_two_output;
            SRC_LOGIC_ONE:   selected = logic_cell_one_output;
            SRC_LOGIC_TWO:   selected = logic_cell_two_output;
            SRC_LOGIC_THREE: selected = logic_cell_three_output;
            SRC_LOGIC_FOUR:  selected = logic_cell_four_output;
            SRC_PWM_THREE:   selected = pulse_width_three_output;
            SRC_PWM_FOUR:    selected = pulse_width_four_output;
            default: begin
                // Unused codes give a quiet low waveform.
                selected  = 1'b0;
                sel_valid = 1'b0;
            end
        endcase
    end

    // RULE_10: sample on selected clock.
    always_comb begin
        wave_d = wave_q;
        if (step) begin
            wave_d = selected;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wave_q <= WAVE_RESET;
        end else begin
            wave_q <= wave_d;
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    // Outputs A and C carry the waveform, B and D its complement. The
    // complement is formed before polarity so that steering does not
    // depend on how the pins are polarised.
    // RULE_09: steering before polarity.
    assign raw_wave = {4{wave_q}} ^ COMPLEMENT_MASK;

    always_comb begin
        pin_out_d  = pin_out_q;
        pin_en_n_d = pin_en_n_q;
        driving    = 4'h0;
        if (step) begin
            for (int i = 0; i < NUM_OUTPUTS; i++) begin
                // RULE_03: per-output enable.
                // RULE_06: module enable gates all.
                driving[i] = module_enable & output_enable_bits[i];
                if (!driving[i]) begin
                    // RULE_04: release the pin.
                    pin_out_d[i]  = 1'b0;
                    pin_en_n_d[i] = 1'b1;
                end else if (override_select[i]) begin
                    // RULE_05: override has priority.
                    // RULE_08: override not inverted.
                    pin_out_d[i]  = override_levels[i];
                    pin_en_n_d[i] = 1'b0;
                end else begin
                    // RULE_07: apply polarity.
                    pin_out_d[i]  = apply_polarity(raw_wave[i], output_polarity_bits[i]);
                    pin_en_n_d[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_out_q  <= PIN_OUT_RESET;
            pin_en_n_q <= PIN_EN_N_RESET;
        end else begin
            pin_out_q  <= pin_out_d;
            pin_en_n_q <= pin_en_n_d;
        end
    end

    assign pin_out             = pin_out_q;
    assign pin_out_en_n        = pin_en_n_q;
    assign source_level        = wave_q;
    assign source_select_valid = sel_valid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_SOURCE_SAMPLED: assert property ( // RULE_02
        step |=> wave_q == $past(selected))
        else $error("Waveform does not follow the selected source.");

    AST_HOLD_BETWEEN_TICKS: assert property ( // RULE_10
        !step |=> $stable(wave_q) && $stable(pin_out_q) && $stable(pin_en_n_q))
        else $error("Output changed without a selected clock tick.");

    AST_ENABLE_PER_OUTPUT: assert property ( // RULE_03
        step && module_enable |=> pin_en_n_q == ~$past(output_enable_bits))
        else $error("Pin drive does not match its own enable bit.");

    AST_RELEASED_LOW: assert property ( // RULE_04
        step ##1 (pin_en_n_q != 4'h0) |-> (pin_out_q & pin_en_n_q) == 4'h0)
        else $error("Released pin still shows a level.");

    AST_MODULE_DISABLED: assert property ( // RULE_06
        step && !module_enable |=> pin_en_n_q == 4'hF && pin_out_q == 4'h0)
        else $error("Disabled module still controls a pin.");

    AST_OVERRIDE_RAW: assert property ( // RULE_08
        step && module_enable && (output_enable_bits[0] & override_select[0]) |=>
        pin_out_q[0] == $past(override_levels[0]))
        else $error("Override level altered on output A.");

    AST_POLARITY_A: assert property ( // RULE_07
        step && module_enable && output_enable_bits[0] && !override_select[0] |=>
        pin_out_q[0] == ($past(output_polarity_bits[0]) ? $past(wave_q) : ~$past(wave_q)))
        else $error("Polarity wrong on output A.");

    AST_COMPLEMENT_PAIR: assert property ( // RULE_09
        step && module_enable && (output_enable_bits[1:0] == 2'h3) && (override_select[1:0] == 2'h0) &&
        (output_polarity_bits[1] == output_polarity_bits[0]) |=> pin_out_q[1] != pin_out_q[0])
        else $error("Steering pair not complementary under equal polarity.");

    AST_WAVE_OR_OVERRIDE: assert property ( // RULE_05
        step && module_enable && output_enable_bits[2] && !override_select[2] ##1
        step && module_enable && output_enable_bits[2] && !override_select[2] && $stable(output_polarity_bits[2])
        && $stable(wave_q) |=> $stable(pin_out_q[2]))
        else $error("Output C does not track a steady waveform.");

    COV_FAST_DRIVE: cover property (
        clock_source_select && step && module_enable && output_enable_bits[0] ##1 !pin_en_n_q[0]);
    COV_OVERRIDE_USED: cover property (
        step && module_enable && output_enable_bits[3] && override_select[3]);
    COV_ACTIVE_LOW: cover property (
        step && module_enable && output_enable_bits[1] && !output_polarity_bits[1]);
    COV_DISABLE_RELEASE: cover property (
        pin_en_n_q != 4'hF ##1 step && !module_enable ##1 pin_en_n_q == 4'hF);

endmodule

`default_nettype wire

// ### testbench/wgsoc_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module wgsoc_source_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Control from the bench
    input  wire logic [10:0] levels,
    input  wire logic        toggle,
    // Waveform sources, index equals select code
    output logic [10:0]      sources
);

    // ****************************************************************
    // Source registers
    // ****************************************************************
    logic [10:0] src_d;
    logic [10:0] src_q;

    // Toggling every line each cycle gives the worst case for sampling.
    // eleven source lines
    always_comb begin
        src_d = toggle ? ~src_q : levels;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            src_q <= 11'h000;
        end else begin
            src_q <= src_d;
        end
    end

    assign sources = src_q;

endmodule

`default_nettype wire

// ### testbench/test_waveform_gen_source_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module test_waveform_gen_source_output_ctrl;
    import wgsoc_pkg::*;

    logic        clock;
    logic        reset;
    logic        clock_enable;
    logic        module_enable;
    logic        clock_source_select;
    logic [3:0]  input_select;
    logic [3:0]  oe;
    logic [3:0]  pol;
    logic [3:0]  ovr_sel;
    logic [3:0]  ovr_lvl;
    logic [10:0] levels;
    logic        toggle;
    logic [10:0] sources;
    logic [3:0]  pin_out;
    logic [3:0]  pin_out_en_n;
    logic        source_level;
    logic        source_select_valid;
    logic [7:0]  snap;
    logic        last;
    int          seed;
    int          n_mismatch;
    int          n_tests;
    int          cycles;
    int          cnt;

    wgsoc_source_output u_dut (
        .clock(clock), .reset(reset), .clock_enable(clock_enable), .module_enable(module_enable),
        .clock_source_select(clock_source_select), .input_select(input_select), .output_enable_bits(oe),
        .output_polarity_bits(pol), .override_select(ovr_sel), .override_levels(ovr_lvl),
        .peripheral_pin_remap(sources[0]), .comparator_one_synced(sources[1]),
        .comparator_two_synced(sources[2]), .capture_compare_one_output(sources[3]),
        .capture_compare_two_output(sources[4]), .logic_cell_one_output(sources[5]),
        .logic_cell_two_output(sources[6]), .logic_cell_three_output(sources[7]),
        .logic_cell_four_output(sources[8]), .pulse_width_three_output(sources[9]),
        .pulse_width_four_output(sources[10]), .pin_out(pin_out), .pin_out_en_n(pin_out_en_n),
        .source_level(source_level), .source_select_valid(source_select_valid)
    );

    wgsoc_source_model u_model (
        .clock(clock), .reset(reset), .levels(levels), .toggle(toggle), .sources(sources)
    );

    // ****************************************************************
    // Expectations
    // ****************************************************************
    function automatic logic exp_wave();
        return (input_select < 4'hB) ? levels[input_select] : 1'b0;
    endfunction

    function automatic logic [7:0] exp_pins();
        logic [3:0] en_n;
        logic [3:0] out;
        logic       raw;
        en_n = 4'hF;
        out  = 4'h0;
        for (int i = 0; i < 4; i++) begin
            raw = exp_wave() ^ COMPLEMENT_MASK[i];
            if (module_enable && oe[i]) begin
                en_n[i] = 1'b0;
                out[i]  = ovr_sel[i] ? ovr_lvl[i] : (pol[i] ? raw : ~raw);
            end
        end
        return {en_n, out};
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        check("reset_state", {PIN_EN_N_RESET, PIN_OUT_RESET}, {pin_out_en_n, pin_out});
        check("reset_source", 8'h00, {7'h00, source_level});
        reset = 1'b0;
    endtask

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // The run needs about seven hundred cycles; five thousand means a hang.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 95;
        {clock_enable, module_enable, clock_source_select, toggle} = 4'h8;
        {input_select, oe, pol, ovr_sel, ovr_lvl} = 20'h00000;
        levels = 11'h000;
        do_reset();
        for (int i = 0; i < 48; i++) begin
            @(posedge clock);
            #1;
            input_select        = 4'(i % 16);
            module_enable       = (i % 8) != 7;
            clock_source_select = 1'($random(seed));
            levels              = 11'($random(seed));
            oe                  = 4'($random(seed));
            pol                 = 4'($random(seed));
            ovr_sel             = 4'($random(seed) & $random(seed));
            ovr_lvl             = 4'($random(seed));
            repeat (12) @(posedge clock);
            #1;
            check("pins", exp_pins(), {pin_out_en_n, pin_out});
            check("source", {7'h00, exp_wave()}, {7'h00, source_level});
            check("valid", {7'h00, input_select < 4'hB}, {7'h00, source_select_valid});
        end
        {module_enable, oe, pol, ovr_sel, input_select} = {1'b1, 12'hFF0, SRC_COMP_ONE};
        toggle = 1'b1;
        for (int s = 0; s < 2; s++) begin
            clock_source_select = s[0];
            repeat (4) @(posedge clock);
            #1;
            cnt  = 0;
            last = source_level;
            repeat (25) begin
                @(posedge clock);
                #1;
                cnt += (source_level !== last);
                last = source_level;
            end
            if (s == 0) begin
                check("sys_changes", 8'h19, 8'(cnt));
            end else begin
                check("fast_changes", 8'h01, {7'h00, cnt >= 1 && cnt <= 16});
            end
        end
        clock_enable = 1'b0;
        #1;
        snap = {pin_out_en_n, pin_out};
        last = source_level;
        repeat (6) @(posedge clock);
        #1;
        check("frozen_pins", snap, {pin_out_en_n, pin_out});
        check("frozen_source", {7'h00, last}, {7'h00, source_level});
        clock_enable = 1'b1;
        toggle       = 1'b0;
        do_reset();
        report_and_stop();
    end

endmodule

`default_nettype wire
